// File: core/dds_status_if.sv
// drive status, fault latch and flux qualification with an axi4-lite register port
// How it works
// RULE1: ready and settled together mark valid operation
// RULE2: not ready blocks reads, writes and seeks
// RULE3: not ready parks heads at landing zone
// RULE4: ready asserts at 90 percent spindle speed
// RULE5: ready typically about 20 s after power
// RULE6: write fault blocks writing and stays latched
// RULE7: fault clears after condition gone and deselect
// RULE8: fault is write current without write gate
// RULE9: settled asserts when heads rest on track
// RULE10: host avoids transfers while not settled
// RULE11: settled low during power-on recalibration
// RULE12: settled drops 500 ns after first step
// RULE13: settled shown only while unit selected
// RULE14: write flux per rising pair edge, gated
// RULE15: host holds write pair inactive when reading
// RULE16: read pair pulses per flux when not writing
// RULE17: selected status when strap-matching select active
// RULE18: every power-on starts recalibration to zero
// RULE19: no seeking before spindle reaches speed
// RULE20: status outputs enabled only while selected
// RULE21: write gate active low, high allows steps
// RULE22: deselect interval counted, restarted on select
`timescale 1ns/1ns
`include "dds_consts.svh"
module dds_status_if (
  // clock, reset, enable
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  // axi4-lite write channels
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  output logic [1:0]        s_axi_bresp,
  // axi4-lite read channels
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  input  wire logic [7:0]   s_axi_araddr,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  // host pins, asynchronous
  input  wire logic [3:0]   unit_sel_n,
  input  wire logic [1:0]   unit_strap,
  input  wire logic         write_gate_n,
  input  wire logic         step_n,
  input  wire logic         encoded_flux_out_p,
  input  wire logic         encoded_flux_out_n,
  output logic              encoded_flux_in_p,
  output logic              encoded_flux_in_n,
  output dds_pkg::dds_stat_s stat_out,
  output dds_pkg::dds_stat_s stat_oe,
  // drive internals, same clock
  input  wire logic [6:0]   spindle_pct,
  input  wire logic         write_current,
  input  wire logic         heads_at_rest,
  input  wire logic         at_track0,
  input  wire logic         flux_detect,
  output logic              flux_write,
  output dds_pkg::dds_act_s act
);
  // -------------------------------------------------------------------------
  // pin synchronisers and timers
  // -------------------------------------------------------------------------
  logic [9:0]          pins_s;
  logic [3:0]          sel_n_s;
  logic [1:0]          strap_s;
  logic                wg_n_s;
  logic                step_n_s;
  logic                fo_p_s;
  logic                fo_n_s;
  logic                step_done;
  logic                desel_done;
  logic                selected;
  logic                step_edge;
  logic                step_ok;
  logic                step_first;
  logic                settled;
  logic                wr_diff;
  logic                wr_rise;
  logic                write_en;
  logic                read_en;
  logic                fault_cond;

  dds_sync #(.W(10)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       ({unit_sel_n, unit_strap, write_gate_n, step_n, encoded_flux_out_p, encoded_flux_out_n}),
    .q       (pins_s)
  );
  assign {sel_n_s, strap_s, wg_n_s, step_n_s, fo_p_s, fo_n_s} = pins_s;

  dds_timer u_step_tmr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .clr     (step_first),  // later steps of a series keep the first drop time [RULE12]
    .limit   (8'(`DDS_STEP_DROP_CYC)),
    .done    (step_done)
  );

  // restarts whenever the unit is selected again [RULE22]
  dds_timer u_desel_tmr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .clr     (selected),
    .limit   (8'(`DDS_DESEL_CYC)),
    .done    (desel_done)
  );

  // -------------------------------------------------------------------------
  // state registers
  // -------------------------------------------------------------------------
  dds_pkg::dds_state_e state_reg, state_next;
  logic                ready_reg, ready_next;
  logic                fault_reg, fault_next;
  logic [1:0]          strap_reg, strap_next;
  logic [1:0]          scap_reg, scap_next;
  logic                step_n_d_reg, step_n_d_next;
  logic                wr_diff_d_reg, wr_diff_d_next;
  logic                flux_write_next;
  logic                flux_in_p_next;
  dds_pkg::dds_stat_s  stat_oe_next;
  dds_pkg::dds_act_s   act_next;
  logic                rezero_reg, rezero_next;
  logic                winh_reg, winh_next;

  // no unit counts as selected until the strap is caught, after the synchroniser fills
  assign selected   = ~sel_n_s[strap_reg] & (scap_reg == 2'h3); // [RULE17]
  assign step_first = step_ok & (state_reg == dds_pkg::DDS_SETTLED);
  assign step_edge  = step_n_d_reg & ~step_n_s;
  assign step_ok    = step_edge & wg_n_s & ready_reg             // [RULE21] [RULE2]
                      & (state_reg != dds_pkg::DDS_SPINUP) & (state_reg != dds_pkg::DDS_RECAL);
  assign settled    = (state_reg == dds_pkg::DDS_SETTLED) | (state_reg == dds_pkg::DDS_STEP_WAIT);
  // inactive pair sits with p below n, so p high and n low is the active leg [RULE15]
  assign wr_diff    = fo_p_s & ~fo_n_s;
  assign wr_rise    = wr_diff & ~wr_diff_d_reg;
  assign fault_cond = write_current & wg_n_s;                    // [RULE8]
  // writing needs ready, settled heads, no fault and write gate low [RULE1] [RULE10] [RULE6]
  assign write_en   = ready_reg & settled & ~fault_reg & ~wg_n_s & ~winh_reg;
  assign read_en    = ready_reg & wg_n_s;

  // head positioning, fault latch and pin qualification
  always_comb
  begin
    // threshold on speed alone; the ~20 s spin-up is the motor's, not timed here [RULE4] [RULE5]
    ready_next = (spindle_pct >= `DDS_READY_PCT);
    state_next = state_reg;
    unique case (state_reg)
      dds_pkg::DDS_SPINUP:    if (ready_reg) state_next = dds_pkg::DDS_RECAL;      // [RULE18] [RULE19]
      dds_pkg::DDS_RECAL:     if (at_track0 && heads_at_rest) state_next = dds_pkg::DDS_SETTLED; // [RULE9]
      dds_pkg::DDS_SETTLED:
        if (rezero_reg)
          state_next = dds_pkg::DDS_RECAL;
        else if (step_ok)
          state_next = dds_pkg::DDS_STEP_WAIT;
      dds_pkg::DDS_STEP_WAIT: if (step_done) state_next = dds_pkg::DDS_SEEKING;    // [RULE12]
      dds_pkg::DDS_SEEKING:   if (heads_at_rest && !step_ok) state_next = dds_pkg::DDS_SETTLED; // [RULE9]
      default:                state_next = dds_pkg::DDS_SPINUP;
    endcase
    // losing speed overrides any seek and parks the heads [RULE3] [RULE2]
    if (!ready_reg)
      state_next = dds_pkg::DDS_SPINUP;
    // set wins over clear; clear needs condition gone and long deselect [RULE6] [RULE7]
    fault_next      = fault_cond | (fault_reg & ~desel_done);
    scap_next       = (scap_reg == 2'h3) ? scap_reg : scap_reg + 2'h1;
    strap_next      = (scap_reg == 2'h2) ? strap_s : strap_reg;
    step_n_d_next   = step_n_s;
    wr_diff_d_next  = wr_diff;
    flux_write_next = wr_rise & write_en;                        // [RULE14]
    flux_in_p_next  = flux_detect & read_en;                     // [RULE16]
    // every status line is gated by the unit's own select [RULE20] [RULE13] [RULE11]
    stat_oe_next.ready          = ready_reg & selected;
    stat_oe_next.write_fault    = fault_reg & selected;
    stat_oe_next.seek_complete  = settled & ready_reg & selected;
    stat_oe_next.drive_selected = selected;                      // [RULE17]
    act_next.park  = (state_next == dds_pkg::DDS_SPINUP);        // [RULE3]
    act_next.recal = (state_next == dds_pkg::DDS_RECAL);         // [RULE18]
    act_next.step  = step_ok;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg         <= dds_pkg::DDS_SPINUP;
      ready_reg         <= 1'b0;
      fault_reg         <= 1'b0;
      strap_reg         <= 2'h0;
      scap_reg          <= 2'h0;
      step_n_d_reg      <= 1'b0;  // matches the synchroniser's reset, so no false edge
      wr_diff_d_reg     <= 1'b0;
      flux_write        <= 1'b0;
      encoded_flux_in_p <= 1'b0;
      encoded_flux_in_n <= 1'b1;
      stat_oe           <= '0;
      act               <= 3'h4;
    end
    else if (ce)
    begin
      state_reg         <= state_next;
      ready_reg         <= ready_next;
      fault_reg         <= fault_next;
      strap_reg         <= strap_next;
      scap_reg          <= scap_next;
      step_n_d_reg      <= step_n_d_next;
      wr_diff_d_reg     <= wr_diff_d_next;
      flux_write        <= flux_write_next;
      encoded_flux_in_p <= flux_in_p_next;
      encoded_flux_in_n <= ~flux_in_p_next;
      stat_oe           <= stat_oe_next;
      act               <= act_next;
    end
  end

  // open-collector lines only ever pull low
  assign stat_out = '0;

  // -------------------------------------------------------------------------
  // axi4-lite slave
  // -------------------------------------------------------------------------
  logic        awh_reg, awh_next;
  logic        wh_reg, wh_next;
  logic [7:0]  awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic        ws_reg, ws_next;
  logic        bv_reg, bv_next;
  logic [1:0]  br_reg, br_next;
  logic        rv_reg, rv_next;
  logic [31:0] rd_reg, rd_next;
  logic [1:0]  rr_reg, rr_next;
  logic [31:0] status_word;

  assign status_word = {23'h000000, selected, settled, fault_reg, ready_reg, state_reg};
  // channels close while a response waits, so one write is in flight at a time
  assign s_axi_awready = ~awh_reg & ~bv_reg;
  assign s_axi_wready  = ~wh_reg & ~bv_reg;
  assign s_axi_arready = ~rv_reg;

  // address and data accepted in either order, committed once both are held
  always_comb
  begin
    awh_next    = awh_reg | (s_axi_awvalid & s_axi_awready);
    wh_next     = wh_reg | (s_axi_wvalid & s_axi_wready);
    awa_next    = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awa_reg;
    wd_next     = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wd_reg;
    ws_next     = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb[0] : ws_reg;
    bv_next     = bv_reg & ~s_axi_bready;
    br_next     = br_reg;
    rezero_next = 1'b0;
    winh_next   = winh_reg;
    if (awh_reg && wh_reg && !bv_reg)
    begin
      awh_next = 1'b0;
      wh_next  = 1'b0;
      bv_next  = 1'b1;
      if (awa_reg == `DDS_REG_CTRL)
      begin
        br_next = `DDS_RESP_OKAY;
        if (ws_reg)
        begin
          rezero_next = wd_reg[`DDS_CTRL_REZERO];
          winh_next   = wd_reg[`DDS_CTRL_WINH];
        end
      end
      else if (awa_reg == `DDS_REG_STATUS)
        br_next = `DDS_RESP_SLVERR;  // read-only
      else
        br_next = `DDS_RESP_DECERR;
    end
    rv_next = rv_reg & ~s_axi_rready;
    rd_next = rd_reg;
    rr_next = rr_reg;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rv_next = 1'b1;
      rr_next = `DDS_RESP_OKAY;
      if (s_axi_araddr == `DDS_REG_CTRL)
        rd_next = {30'h00000000, winh_reg, 1'b0};
      else if (s_axi_araddr == `DDS_REG_STATUS)
        rd_next = status_word;
      else
      begin
        rd_next = 32'h00000000;
        rr_next = `DDS_RESP_DECERR;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awh_reg    <= 1'b0;
      wh_reg     <= 1'b0;
      awa_reg    <= 8'h00;
      wd_reg     <= 32'h00000000;
      ws_reg     <= 1'b0;
      bv_reg     <= 1'b0;
      br_reg     <= 2'h0;
      rv_reg     <= 1'b0;
      rd_reg     <= 32'h00000000;
      rr_reg     <= 2'h0;
      rezero_reg <= `DDS_CTRL_RESET;
      winh_reg   <= `DDS_CTRL_RESET;
    end
    else if (ce)
    begin
      awh_reg    <= awh_next;
      wh_reg     <= wh_next;
      awa_reg    <= awa_next;
      wd_reg     <= wd_next;
      ws_reg     <= ws_next;
      bv_reg     <= bv_next;
      br_reg     <= br_next;
      rv_reg     <= rv_next;
      rd_reg     <= rd_next;
      rr_reg     <= rr_next;
      rezero_reg <= rezero_next;
      winh_reg   <= winh_next;
    end
  end

  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp  = br_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata  = rd_reg;
  assign s_axi_rresp  = rr_reg;

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_step_taken;
    ce && (state_reg == dds_pkg::DDS_SETTLED) && !rezero_reg && step_ok;
  endsequence
  sequence s_drop_after;
    (ce && settled) [*8] ##[110:125] !settled;
  endsequence

  a_ready_speed: assert property (ce |=> ready_reg == ($past(spindle_pct) >= `DDS_READY_PCT)) // [RULE4]
    else $error("ready does not follow spindle speed");
  a_park_unready: assert property ((ce && !ready_reg) |=> act.park && !act.step) // [RULE3]
    else $error("heads not parked while not ready");
  a_block_unready: assert property ((ce && !ready_reg) |=> !flux_write && !encoded_flux_in_p) // [RULE2]
    else $error("transfer while not ready");
  a_fault_set: assert property ((ce && fault_cond) |=> fault_reg && !flux_write) // [RULE8]
    else $error("fault not latched");
  a_fault_hold: assert property ((ce && fault_reg && !desel_done) |=> fault_reg) // [RULE7]
    else $error("fault cleared without deselect interval");
  a_step_drop: assert property (s_step_taken |=> s_drop_after) // [RULE12]
    else $error("settled did not drop after step delay");
  a_recal_unsettled: assert property ((ce && state_reg == dds_pkg::DDS_RECAL) |=> !stat_oe.seek_complete) // [RULE11]
    else $error("settled shown during recalibration");
  a_sel_gating: assert property ((ce && !selected) |=> stat_oe == '0) // [RULE20]
    else $error("status driven while deselected");
  a_write_flux: assert property (flux_write |-> $past(wr_rise) && !$past(wg_n_s)) // [RULE14]
    else $error("flux written without gated edge");
  a_read_flux: assert property ((ce && flux_detect && read_en) |=> encoded_flux_in_p) // [RULE16]
    else $error("read flux not reported");
  a_spin_recal: assert property ((ce && state_reg == dds_pkg::DDS_SPINUP && ready_reg) |=> act.recal) // [RULE18]
    else $error("no recalibration after spin-up");
  a_desel_restart: assert property ((ce && selected) |=> !desel_done) // [RULE22]
    else $error("deselect count not restarted");
endmodule // dds_status_if

// File: core/dds_consts.svh
// timing, offsets, field positions and reset values of the drive status block
`ifndef DDS_CONSTS_SVH
`define DDS_CONSTS_SVH
// ---------------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------------
`define DDS_CLK_PERIOD_NS 4
`define DDS_STEP_DROP_NS  500
`define DDS_STEP_DROP_CYC (((`DDS_STEP_DROP_NS) + (`DDS_CLK_PERIOD_NS) - 1) / (`DDS_CLK_PERIOD_NS))
`define DDS_DESEL_MIN_NS  500
`define DDS_DESEL_CYC     (((`DDS_DESEL_MIN_NS) + (`DDS_CLK_PERIOD_NS) - 1) / (`DDS_CLK_PERIOD_NS))
`define DDS_READY_PCT     7'h5A
// ---------------------------------------------------------------------------
// register map
// ---------------------------------------------------------------------------
`define DDS_REG_CTRL      8'h00
`define DDS_REG_STATUS    8'h04
`define DDS_CTRL_REZERO   0
`define DDS_CTRL_WINH     1
`define DDS_CTRL_RESET    1'h0
`define DDS_STS_READY     5
`define DDS_STS_FAULT     6
`define DDS_STS_SETTLED   7
`define DDS_STS_SELECTED  8
`define DDS_RESP_OKAY     2'h0
`define DDS_RESP_SLVERR   2'h2
`define DDS_RESP_DECERR   2'h3
`endif

// File: core/dds_pkg.sv
// types shared by the drive status block
package dds_pkg;
  // head positioning states, one-hot
  typedef enum logic [4:0] {
    DDS_SPINUP    = 5'h01,
    DDS_RECAL     = 5'h02,
    DDS_SETTLED   = 5'h04,
    DDS_STEP_WAIT = 5'h08,
    DDS_SEEKING   = 5'h10
  } dds_state_e;
  // open-collector status lines towards the host
  typedef struct packed {
    logic ready;
    logic write_fault;
    logic seek_complete;
    logic drive_selected;
  } dds_stat_s;
  // commands towards the actuator servo
  typedef struct packed {
    logic park;
    logic recal;
    logic step;
  } dds_act_s;
endpackage

// File: core/dds_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module dds_sync #(
  parameter int W = 1
) (
  // clock and control
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  // first stage is read only by the second
  always_comb
  begin
    meta_next = ce ? d : meta_reg;
    q_next    = ce ? meta_reg : q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end
endmodule // dds_sync

// File: core/dds_timer.sv
// saturating interval counter with synchronous restart
`timescale 1ns/1ns
module dds_timer (
  // clock and control
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // counting
  input  wire logic       clr,
  input  wire logic [7:0] limit,
  output logic            done
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;

  // saturates so done stays high until the next restart
  always_comb
  begin
    cnt_next = cnt_reg;
    if (clr)
      cnt_next = 8'h00;
    else if (cnt_reg != limit)
      cnt_next = cnt_reg + 8'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_reg <= 8'h00;
    else if (ce)
      cnt_reg <= cnt_next;
  end

  assign done = (cnt_reg == limit);
endmodule // dds_timer

// File: tb/dds_host_model.sv
// host controller model driving select, step, write gate and write pair
`timescale 1ns/1ns
module dds_host_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // commands from the bench
  input  wire logic [3:0] cmd_sel,
  input  wire logic       cmd_write,
  input  wire logic       cmd_step,
  input  wire logic       cmd_flux,
  input  wire logic       settled,
  // drive pins
  output logic [3:0]      unit_sel_n,
  output logic            write_gate_n,
  output logic            step_n,
  output logic            flux_p,
  output logic            flux_n
);
  logic [2:0] step_cnt;
  logic [2:0] flux_cnt;
  // pulses stretched so the drive's synchroniser sees every level
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      step_cnt     <= 3'h0;
      flux_cnt     <= 3'h0;
      unit_sel_n   <= 4'hF;
      write_gate_n <= 1'h1;
    end
    else
    begin
      unit_sel_n   <= ~cmd_sel;
      write_gate_n <= !(cmd_write && settled);
      step_cnt     <= cmd_step ? 3'h4 : step_cnt - (step_cnt != 3'h0);
      flux_cnt     <= cmd_flux ? 3'h6 : flux_cnt - (flux_cnt != 3'h0);
    end
  end
  // write pair held inactive whenever the gate is not active
  assign step_n = (step_cnt == 3'h0);
  assign flux_p = !write_gate_n && (flux_cnt > 3'h3);
  assign flux_n = !flux_p;
endmodule // dds_host_model

// File: tb/dds_status_if_test.sv
// self-checking bench of the drive status block
`timescale 1ns/1ns
`include "dds_consts.svh"
`define CHK(nm, got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module dds_status_if_test;
  logic               aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic               arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid;
  logic [7:0]         awaddr = 8'h00, araddr = 8'h00, busy = 8'h00;
  logic [31:0]        wdata = 32'h0, rdata, rnd = 32'h9D17EE6E;
  logic [1:0]         bresp, rresp, eb, strap = 2'h0;
  logic [3:0]         sel_n, cmd_sel = 4'h0, me = 4'h1;
  logic               gate_n, step_n, fo_p, fo_n, fi_p, fi_n, flux_write;
  logic               cmd_write = 1'h0, cmd_step = 1'h0, cmd_flux = 1'h0, write_current = 1'h0;
  logic               heads_at_rest = 1'h0, at_track0 = 1'h0, flux_detect = 1'h0;
  logic [6:0]         spindle_pct = 7'h00;
  logic [33:0]        er;
  logic [33:0]        rq[$];
  logic [1:0]         bq[$];
  dds_pkg::dds_stat_s stat_out, stat_oe;
  dds_pkg::dds_act_s  act;
  int                 fails = 0, num_checks = 0, n_step = 0, n_fw = 0, n_fi = 0, n_rc = 0, c0, c1, n;

  always #2 aclk = ~aclk;

  dds_status_if uut (.aclk(aclk), .aresetn(aresetn), .ce(1'h1),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .unit_sel_n(sel_n), .unit_strap(strap), .write_gate_n(gate_n), .step_n(step_n),
    .encoded_flux_out_p(fo_p), .encoded_flux_out_n(fo_n), .encoded_flux_in_p(fi_p),
    .encoded_flux_in_n(fi_n), .stat_out(stat_out), .stat_oe(stat_oe), .spindle_pct(spindle_pct),
    .write_current(write_current), .heads_at_rest(heads_at_rest), .at_track0(at_track0),
    .flux_detect(flux_detect), .flux_write(flux_write), .act(act));

  dds_host_model host (.aclk(aclk), .aresetn(aresetn), .cmd_sel(cmd_sel), .cmd_write(cmd_write),
    .cmd_step(cmd_step), .cmd_flux(cmd_flux), .settled(stat_oe.seek_complete), .unit_sel_n(sel_n),
    .write_gate_n(gate_n), .step_n(step_n), .flux_p(fo_p), .flux_n(fo_n));

  // ---------------------------------------------------------------------------
  // actuator stand-in and watchers
  // ---------------------------------------------------------------------------
  // a step keeps the heads moving 200 cycles, longer than the settled drop
  always @(posedge aclk)
  begin
    busy <= act.step ? 8'hC8 : busy - (busy != 8'h00);
    heads_at_rest <= (busy == 8'h00) && !act.park;
    at_track0 <= (act.step || act.park) ? 1'h0 : (at_track0 || (act.recal && busy == 8'h00));
    n_step += (act.step === 1'h1);
    n_fw += (flux_write === 1'h1);
    n_fi += (fi_p === 1'h1 && fi_n === 1'h0);
    n_rc += (act.recal === 1'h1);
  end
  // oldest expectation against each bus answer
  always @(posedge aclk)
  begin
    if (rvalid && rready)
    begin
      er = rq.pop_front();
      `CHK("rdata", rdata, er[31:0])
      `CHK("rresp", rresp, er[33:32])
    end
    if (bvalid && bready)
    begin
      eb = bq.pop_front();
      `CHK("bresp", bresp, eb)
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic pulse_step();
    cmd_step <= 1'h1;
    tick(1);
    cmd_step <= 1'h0;
    tick(20);
  endtask
  // the first edge keeps a release and a new request apart
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    tick(1);
    bq.push_back(e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ad && wd))
    begin
      tick(1);
      ad = ad || awready;
      wd = wd || wready;
      awvalid <= !ad;
      wvalid <= !wd;
    end
    do tick(1); while (bvalid !== 1'h1);
    bready <= 1'h0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    tick(1);
    rq.push_back({e, d});
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do tick(1); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do tick(1); while (rvalid !== 1'h1);
    rready <= 1'h0;
  endtask
  // host write flux and media flux offered together, counted at both outputs
  task automatic burst(input int k, input int ew, input int ei);
    c0 = n_fw;
    c1 = n_fi;
    repeat (k)
    begin
      cmd_flux <= 1'h1;
      flux_detect <= 1'h1;
      tick(1);
      cmd_flux <= 1'h0;
      flux_detect <= 1'h0;
      tick(9);
    end
    tick(10);
    `CHK("flux_write", n_fw - c0, ew)
    `CHK("flux_in", n_fi - c1, ei)
  endtask
  task automatic wrap_up();
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial
  begin
    tick(10);
    `CHK("oe_reset", stat_oe, 4'h0)
    `CHK("act_reset", act, 3'h4)
    rnd = xs(rnd);
    me = 4'h1 << rnd[1:0];
    strap <= rnd[1:0];
    aresetn <= 1'h1;
    cmd_sel <= me;
    spindle_pct <= 7'h59;
    tick(40);
    `CHK("oe_slow", stat_oe, 4'h1)
    pulse_step();
    `CHK("step_slow", n_step, 0)
    axr(`DDS_REG_STATUS, 32'h101, `DDS_RESP_OKAY);
    spindle_pct <= 7'h5A;
    c0 = 0;
    while (stat_oe.ready !== 1'h1 && c0 < 50)
    begin
      tick(1);
      c0++;
    end
    `CHK("settled_recal", stat_oe.seek_complete, 1'h0)
    tick(20);
    `CHK("oe_ready", stat_oe, 4'hB)
    axr(`DDS_REG_STATUS, 32'h1A4, `DDS_RESP_OKAY);
    rnd = xs(rnd);
    axw(`DDS_REG_CTRL, rnd & 32'hFFFFFFFE, `DDS_RESP_OKAY);
    axr(`DDS_REG_CTRL, {30'h0, rnd[1], 1'h0}, `DDS_RESP_OKAY);
    axw(`DDS_REG_STATUS, rnd, `DDS_RESP_SLVERR);
    axw(8'h10, rnd, `DDS_RESP_DECERR);
    axr(8'h10, 32'h0, `DDS_RESP_DECERR);
    axw(`DDS_REG_CTRL, 32'h0, `DDS_RESP_OKAY);
    pulse_step();
    tick(40);
    `CHK("settled_hold", stat_oe.seek_complete, 1'h1)
    tick(100);
    `CHK("settled_drop", stat_oe.seek_complete, 1'h0)
    `CHK("step_fwd", n_step, 1)
    tick(300);
    `CHK("oe_seek_done", stat_oe, 4'hB)
    c0 = n_rc;
    axw(`DDS_REG_CTRL, 32'h1, `DDS_RESP_OKAY);
    axr(`DDS_REG_CTRL, 32'h0, `DDS_RESP_OKAY);
    tick(20);
    `CHK("rezero", n_rc > c0, 1'h1)
    `CHK("oe_rezero", stat_oe, 4'hB)
    cmd_write <= 1'h1;
    tick(6);
    write_current <= 1'h1;
    rnd = xs(rnd);
    n = rnd[2:0] + 1;
    burst(n, n, 0);
    axr(`DDS_REG_STATUS, 32'h1A4, `DDS_RESP_OKAY);
    axw(`DDS_REG_CTRL, 32'h2, `DDS_RESP_OKAY);
    burst(n, 0, 0);
    axw(`DDS_REG_CTRL, 32'h0, `DDS_RESP_OKAY);
    write_current <= 1'h0;
    tick(1);
    cmd_write <= 1'h0;
    tick(6);
    burst(n, 0, n);
    cmd_sel <= {me[2:0], me[3]};
    tick(10);
    `CHK("oe_other", stat_oe, 4'h0)
    axr(`DDS_REG_STATUS, 32'h0A4, `DDS_RESP_OKAY);
    cmd_sel <= me;
    write_current <= 1'h1;
    tick(10);
    `CHK("oe_fault", stat_oe, 4'hF)
    cmd_write <= 1'h1;
    tick(6);
    burst(n, 0, 0);
    cmd_write <= 1'h0;
    tick(6);
    write_current <= 1'h0;
    tick(300);
    axr(`DDS_REG_STATUS, 32'h1E4, `DDS_RESP_OKAY);
    cmd_sel <= 4'h0;
    tick(100);
    cmd_sel <= me;
    tick(10);
    axr(`DDS_REG_STATUS, 32'h1E4, `DDS_RESP_OKAY);
    cmd_sel <= 4'h0;
    tick(200);
    cmd_sel <= me;
    tick(10);
    axr(`DDS_REG_STATUS, 32'h1A4, `DDS_RESP_OKAY);
    spindle_pct <= 7'h32;
    tick(20);
    `CHK("park", act.park, 1'h1)
    `CHK("oe_lost", stat_oe, 4'h1)
    pulse_step();
    burst(2, 0, 0);
    `CHK("step_lost", n_step, 1)
    axr(`DDS_REG_STATUS, 32'h101, `DDS_RESP_OKAY);
    wrap_up();
  end
  // hang guard, well beyond the under two thousand cycles the scenarios need
  initial
  begin
    tick(20000);
    fails++;
    wrap_up();
  end
endmodule // dds_status_if_test
